// [core/mcwh_params.svh]
`ifndef MCWH_PARAMS_SVH
`define MCWH_PARAMS_SVH
// ----------------------------------------
// Word indexes of the ten-word images
// ----------------------------------------
`define MCWH_W_CFG_A 4'h0
`define MCWH_W_CFG_B 4'h1
`define MCWH_W_SPD_HI 4'h2
`define MCWH_W_SPD_LO 4'h3
`define MCWH_W_STEPS 4'h4
`define MCWH_W_ZERO 4'h5
`define MCWH_W_ENC_RES 4'h6
`define MCWH_W_IDLE 4'h7
`define MCWH_W_CURR 4'h8
`define MCWH_W_STATUS 4'h9
// ----------------------------------------
// Field positions, word A
// ----------------------------------------
`define MCWH_A_MODE 15
`define MCWH_A_STALL 13
`define MCWH_A_ENC 10
`define MCWH_A_RSVD_MASK 16'h13c0
// ----------------------------------------
// Field positions, word B
// ----------------------------------------
`define MCWH_B_IGNORED 15
`define MCWH_B_READBACK 11
`define MCWH_B_PERSIST 10
`define MCWH_B_RPT_FMT 9
`define MCWH_B_PRM_FMT 8
`define MCWH_B_ORDER 7
`define MCWH_B_IN2_POL 1
`define MCWH_B_IN1_POL 0
`define MCWH_B_RSVD_MASK 16'h707c
// ----------------------------------------
// Values and ranges
// ----------------------------------------
`define MCWH_SAVE_OK 16'haaaa
`define MCWH_SAVE_FAIL 16'heeee
`define MCWH_FUNC_GP 3'h0
`define MCWH_FUNC_BAD 3'h7
`define MCWH_SPD_LO_MAX 16'h03e7
`define MCWH_STEPS_MIN 16'h00c8
`define MCWH_STEPS_MAX 16'h7fff
`define MCWH_RES_1K 16'h0400
`define MCWH_RES_2K 16'h0800
`define MCWH_RES_4K 16'h1000
`define MCWH_IDLE_MAX 16'h0064
`define MCWH_CURR_MIN 16'h0001
`define MCWH_CURR_MAX 16'h0022
`define MCWH_RESET_WORD 16'h0000
`endif

// [core/mcwh_pkg.sv]
package mcwh_pkg;
  typedef enum logic [2:0] {
    MCWH_RUN  = 3'b001,
    MCWH_SAVE = 3'b010,
    MCWH_HALT = 3'b100
  } mcwh_state_e;
  typedef logic [15:0] mcwh_word_t;
endpackage

// [core/mcwh_handler.sv]
// What this block does
// - Top bit of config word B is ignored whatever its value.
// - Read-back on entry shows held config; writes refused while read-back set.
// - Persist bit rising edge: validate config, then write it to flash.
// - Invalid config: persist edge ignored, no flash write.
// - Flash success: last input word AAAA, status indicator flashes green.
// - Flash failure: last input word EEEE, status indicator flashes red.
// - After save response, no further host commands until power cycle.
// - Report format bit: zero split multi-word, one signed 32-bit.
// - Parameter format bit: zero split multi-word, one signed 32-bit.
// - Word order bit used only if a format bit is one; one is big-endian.
// - Input polarity bits: zero active without current, one active with current.
// - New idle current takes effect when first later move completes.
// - Config mode: input words 0-8 mirror config, word five zero.
// - Config mode: input word nine zero unless reporting save outcome.
// - Invalid config: stay in command mode, flag config error in word zero.
// - Word zero bit 13: stall enable in config mode, error in command mode.
// - Any reserved config bit set makes config invalid.
// - Any parameter out of range, e.g. speed lower word over 999, invalid.
// - Both inputs same function invalid, except both general purpose.
// - Stall detection without encoder in use invalid.
// - Input function code 111 invalid.
// - Encoder-in-use is word A bit 10; stall needs it set.
`include "mcwh_params.svh"
module mcwh_handler
  import mcwh_pkg::*;
#(
  parameter int NWORDS = 10
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Cyclic output image from host
  input wire logic frame_valid,
  input wire logic [15:0] out_word [NWORDS],
  // Cyclic input image to host
  output logic [15:0] in_word [NWORDS],
  output logic config_mode,
  // Flash store port
  output logic flash_req,
  output logic [15:0] flash_data [NWORDS],
  input wire logic flash_done,
  input wire logic flash_ok,
  // Status indicator
  output logic led_flash_green,
  output logic led_flash_red,
  // Applied configuration
  output logic report_fmt_32,
  output logic param_fmt_32,
  output logic word_order_big,
  output logic input_one_polarity,
  output logic input_two_polarity,
  output logic stall_enable,
  output logic encoder_enable,
  // Idle current hand-off
  input wire logic move_done,
  output logic [15:0] idle_current
);

  // ----------------------------------------
  // Validity check of a ten-word image
  // ----------------------------------------
  function automatic logic cfg_valid(input logic [15:0] w [NWORDS]);
    logic ok;
    logic [2:0] f1;
    logic [2:0] f2;
    logic enc;
    ok = 1'b1;
    f1 = w[`MCWH_W_CFG_A][2:0];
    f2 = w[`MCWH_W_CFG_A][5:3];
    enc = w[`MCWH_W_CFG_A][`MCWH_A_ENC];
    if ((w[`MCWH_W_CFG_A] & `MCWH_A_RSVD_MASK) != 16'h0000) ok = 1'b0;
    if ((w[`MCWH_W_CFG_B] & `MCWH_B_RSVD_MASK) != 16'h0000) ok = 1'b0;
    if (w[`MCWH_W_ZERO] != 16'h0000) ok = 1'b0;
    if (w[`MCWH_W_STATUS] != 16'h0000) ok = 1'b0;
    if (w[`MCWH_W_SPD_LO] > `MCWH_SPD_LO_MAX) ok = 1'b0;
    if (w[`MCWH_W_STEPS] < `MCWH_STEPS_MIN) ok = 1'b0;
    if (w[`MCWH_W_STEPS] > `MCWH_STEPS_MAX) ok = 1'b0;
    if (w[`MCWH_W_IDLE] > `MCWH_IDLE_MAX) ok = 1'b0;
    if (w[`MCWH_W_CURR] < `MCWH_CURR_MIN) ok = 1'b0;
    if (w[`MCWH_W_CURR] > `MCWH_CURR_MAX) ok = 1'b0;
    if (enc && w[`MCWH_W_ENC_RES] != `MCWH_RES_1K && w[`MCWH_W_ENC_RES] != `MCWH_RES_2K
        && w[`MCWH_W_ENC_RES] != `MCWH_RES_4K)
      ok = 1'b0;
    if (f1 == f2 && f1 != `MCWH_FUNC_GP) ok = 1'b0;
    if (f1 == `MCWH_FUNC_BAD || f2 == `MCWH_FUNC_BAD) ok = 1'b0;
    if (w[`MCWH_W_CFG_A][`MCWH_A_STALL] && !enc) ok = 1'b0;
    return ok;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  mcwh_state_e state;
  mcwh_state_e next_state;
  logic [15:0] held [NWORDS];
  logic [15:0] next_held [NWORDS];
  logic [15:0] prev_b;
  logic [15:0] next_prev_b;
  logic prev_mode;
  logic next_prev_mode;
  logic readback;
  logic next_readback;
  logic cfg_err;
  logic next_cfg_err;
  logic next_config_mode;
  logic [15:0] status_word;
  logic [15:0] next_status_word;
  logic next_flash_req;
  logic next_led_green;
  logic next_led_red;
  logic idle_pending;
  logic next_idle_pending;
  logic [15:0] next_idle_current;
  logic [15:0] w_b;
  logic frame_ok;
  logic persist_edge;

  // Ignored top bit is dropped before anything but the validity check looks at word B
  always_comb
  begin
    w_b = out_word[`MCWH_W_CFG_B];
    w_b[`MCWH_B_IGNORED] = 1'b0;
  end

  assign frame_ok = cfg_valid(out_word);
  assign persist_edge = w_b[`MCWH_B_PERSIST] && !prev_b[`MCWH_B_PERSIST];

  always_comb
  begin
    next_state = state;
    next_held = held;
    next_prev_b = prev_b;
    next_prev_mode = prev_mode;
    next_readback = readback;
    next_cfg_err = cfg_err;
    next_config_mode = config_mode;
    next_status_word = status_word;
    next_flash_req = 1'b0;
    next_led_green = led_flash_green;
    next_led_red = led_flash_red;
    next_idle_pending = idle_pending;
    next_idle_current = idle_current;
    // Move end applies the pending value first so a new frame can set it again
    if (idle_pending && move_done)
    begin
      next_idle_current = held[`MCWH_W_IDLE];
      next_idle_pending = 1'b0;
    end
    unique case (state)
      MCWH_RUN:
      begin
        if (frame_valid)
        begin
          next_prev_b = w_b;
          next_prev_mode = out_word[`MCWH_W_CFG_A][`MCWH_A_MODE];
          if (!out_word[`MCWH_W_CFG_A][`MCWH_A_MODE])
          begin
            next_config_mode = 1'b0;
            next_readback = 1'b0;
          end
          else if (w_b[`MCWH_B_READBACK])
          begin
            // Held image shown, new words refused
            if (!prev_mode)
            begin
              next_readback = 1'b1;
              next_config_mode = 1'b1;
            end
          end
          else if (frame_ok)
          begin
            next_readback = 1'b0;
            next_config_mode = 1'b1;
            next_cfg_err = 1'b0;
            next_status_word = `MCWH_RESET_WORD;
            for (int i = 0; i < NWORDS; i++)
              next_held[i] = out_word[i];
            next_held[`MCWH_W_CFG_B] = w_b;
            if (out_word[`MCWH_W_IDLE] != held[`MCWH_W_IDLE])
              next_idle_pending = 1'b1;
            if (persist_edge)
            begin
              next_flash_req = 1'b1;
              next_state = MCWH_SAVE;
            end
          end
          else
          begin
            // Invalid words: persist edge dropped, stay in command mode
            next_config_mode = 1'b0;
            next_cfg_err = 1'b1;
            next_readback = 1'b0;
          end
        end
      end
      MCWH_SAVE:
      begin
        if (flash_done)
        begin
          next_state = MCWH_HALT;
          next_status_word = flash_ok ? `MCWH_SAVE_OK : `MCWH_SAVE_FAIL;
          next_led_green = flash_ok;
          next_led_red = !flash_ok;
        end
      end
      MCWH_HALT:
      begin
        // Frames ignored until power cycle
        next_state = MCWH_HALT;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= MCWH_RUN;
      for (int i = 0; i < NWORDS; i++)
        held[i] <= `MCWH_RESET_WORD;
      prev_b <= `MCWH_RESET_WORD;
      prev_mode <= 1'b0;
      readback <= 1'b0;
      cfg_err <= 1'b0;
      config_mode <= 1'b0;
      status_word <= `MCWH_RESET_WORD;
      flash_req <= 1'b0;
      led_flash_green <= 1'b0;
      led_flash_red <= 1'b0;
      idle_pending <= 1'b0;
      idle_current <= `MCWH_RESET_WORD;
    end
    else
    begin
      state <= next_state;
      held <= next_held;
      prev_b <= next_prev_b;
      prev_mode <= next_prev_mode;
      readback <= next_readback;
      cfg_err <= next_cfg_err;
      config_mode <= next_config_mode;
      status_word <= next_status_word;
      flash_req <= next_flash_req;
      led_flash_green <= next_led_green;
      led_flash_red <= next_led_red;
      idle_pending <= next_idle_pending;
      idle_current <= next_idle_current;
    end
  end

  // ----------------------------------------
  // Input image and applied settings
  // ----------------------------------------
  logic [15:0] next_in_word [NWORDS];

  always_comb
  begin
    for (int i = 0; i < NWORDS; i++)
      next_in_word[i] = 16'h0000;
    if (next_config_mode)
    begin
      for (int i = 0; i < NWORDS; i++)
        next_in_word[i] = next_held[i];
      next_in_word[`MCWH_W_ZERO] = 16'h0000;
      next_in_word[`MCWH_W_STATUS] = next_status_word;
    end
    else
      next_in_word[`MCWH_W_CFG_A][`MCWH_A_STALL] = next_cfg_err;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < NWORDS; i++)
        in_word[i] <= 16'h0000;
    else
      in_word <= next_in_word;
  end

  always_comb
  begin
    report_fmt_32 = held[`MCWH_W_CFG_B][`MCWH_B_RPT_FMT];
    param_fmt_32 = held[`MCWH_W_CFG_B][`MCWH_B_PRM_FMT];
    word_order_big = (report_fmt_32 || param_fmt_32)
      && held[`MCWH_W_CFG_B][`MCWH_B_ORDER];
    input_one_polarity = held[`MCWH_W_CFG_B][`MCWH_B_IN1_POL];
    input_two_polarity = held[`MCWH_W_CFG_B][`MCWH_B_IN2_POL];
    stall_enable = held[`MCWH_W_CFG_A][`MCWH_A_STALL];
    encoder_enable = held[`MCWH_W_CFG_A][`MCWH_A_ENC];
    flash_data = held;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_save_ok;
    @(posedge clk_sys) disable iff (!rst_n)
    (state == MCWH_SAVE && flash_done && flash_ok) |=>
      in_word[`MCWH_W_STATUS] == `MCWH_SAVE_OK && led_flash_green && !led_flash_red;
  endproperty
  a_save_ok: assert property (p_save_ok) else $error("save success not reported");

  property p_save_fail;
    @(posedge clk_sys) disable iff (!rst_n)
    (state == MCWH_SAVE && flash_done && !flash_ok) |=>
      in_word[`MCWH_W_STATUS] == `MCWH_SAVE_FAIL && led_flash_red && !led_flash_green;
  endproperty
  a_save_fail: assert property (p_save_fail) else $error("save failure not reported");

  property p_halt_frozen;
    @(posedge clk_sys) disable iff (!rst_n)
    state == MCWH_HALT |=> state == MCWH_HALT && $stable(in_word[0]) && !flash_req;
  endproperty
  a_halt_frozen: assert property (p_halt_frozen) else $error("acted after save");

  property p_invalid_no_flash;
    @(posedge clk_sys) disable iff (!rst_n)
    (state == MCWH_RUN && frame_valid && !w_b[`MCWH_B_READBACK] && !frame_ok)
      |=> !flash_req && !config_mode;
  endproperty
  a_invalid_no_flash: assert property (p_invalid_no_flash) else $error("invalid accepted");

  property p_persist_req;
    @(posedge clk_sys) disable iff (!rst_n)
    (state == MCWH_RUN && frame_valid && out_word[0][`MCWH_A_MODE] && !w_b[`MCWH_B_READBACK]
      && frame_ok && persist_edge) |=> flash_req ##1 !flash_req;
  endproperty
  a_persist_req: assert property (p_persist_req) else $error("no flash request");

  property p_err_bit;
    @(posedge clk_sys) disable iff (!rst_n)
    (state == MCWH_RUN && frame_valid && out_word[0][`MCWH_A_MODE] && !w_b[`MCWH_B_READBACK]
      && !frame_ok) |=> in_word[0][`MCWH_A_STALL] && !in_word[0][`MCWH_A_MODE];
  endproperty
  a_err_bit: assert property (p_err_bit) else $error("config error not flagged");

  property p_word5_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    config_mode |-> in_word[`MCWH_W_ZERO] == 16'h0000 && in_word[1][`MCWH_B_IGNORED] == 1'b0;
  endproperty
  a_word5_zero: assert property (p_word5_zero) else $error("word five not zero");

  property p_readback_refuse;
    @(posedge clk_sys) disable iff (!rst_n)
    (state == MCWH_RUN && frame_valid && out_word[0][`MCWH_A_MODE] && w_b[`MCWH_B_READBACK])
      |=> $stable(held[`MCWH_W_STEPS]) && !flash_req;
  endproperty
  a_readback_refuse: assert property (p_readback_refuse) else $error("write while read-back");

  property p_idle_late;
    @(posedge clk_sys) disable iff (!rst_n)
    !move_done |=> $stable(idle_current);
  endproperty
  a_idle_late: assert property (p_idle_late) else $error("idle current changed early");

  property p_idle_pending_kept;
    @(posedge clk_sys) disable iff (!rst_n)
    (state == MCWH_RUN && frame_valid && out_word[0][`MCWH_A_MODE] && !w_b[`MCWH_B_READBACK]
      && frame_ok && out_word[`MCWH_W_IDLE] != held[`MCWH_W_IDLE]) |=> idle_pending;
  endproperty
  a_idle_pending_kept: assert property (p_idle_pending_kept) else $error("idle update lost");

  property p_status_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    (config_mode && state != MCWH_HALT) |-> in_word[`MCWH_W_STATUS] == 16'h0000;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("word nine not zero");

  c_accept: cover property (@(posedge clk_sys) disable iff (!rst_n) !config_mode ##1 config_mode);
  c_save_ok: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(led_flash_green));
  c_save_fail: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(led_flash_red));
  c_error: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(cfg_err));
  c_readback: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(readback));

endmodule

// [tb/mcwh_flash_model.sv]
// ----------------------------------------
// Flash store partner, answers after DELAY
// ----------------------------------------
module mcwh_flash_model #(
  parameter int DELAY = 3
)(
  // Clock
  input wire logic clk_sys,
  // Store request and result
  input wire logic flash_req,
  input wire logic ok_sel,
  output logic flash_done,
  output logic flash_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    flash_done = 1'b0;
    flash_ok = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (flash_req === 1'b1)
      begin
        repeat (DELAY) @(negedge clk_sys);
        flash_done <= 1'b1;
        flash_ok <= ok_sel;
        @(negedge clk_sys);
        flash_done <= 1'b0;
        // Not qualified outside the pulse
        flash_ok <= ~ok_sel;
      end
    end
  end
endmodule

// [tb/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mcwh_pkg::*;
  logic clk_sys, rst_n, frame_valid, flash_done, flash_ok, move_done, ok_sel;
  logic [15:0] out_word [10];
  logic [15:0] in_word [10];
  logic [15:0] flash_data [10];
  logic config_mode, flash_req, led_flash_green, led_flash_red;
  logic report_fmt_32, param_fmt_32, word_order_big;
  logic input_one_polarity, input_two_polarity, stall_enable, encoder_enable;
  logic [15:0] idle_current;
  int fail_count, total_checks;
  mcwh_handler mcwh_handler_i (.clk_sys, .rst_n, .frame_valid, .out_word, .in_word,
    .config_mode, .flash_req, .flash_data, .flash_done, .flash_ok, .led_flash_green,
    .led_flash_red, .report_fmt_32, .param_fmt_32, .word_order_big, .input_one_polarity,
    .input_two_polarity, .stall_enable, .encoder_enable, .move_done, .idle_current);
  mcwh_flash_model mcwh_flash_model_i (.clk_sys, .flash_req, .ok_sel, .flash_done,
    .flash_ok);
  // ----------------------------------------
  // Clock, watchdog, verdict
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100us;
    fail_count++;
    end_sim();
  end
  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
  endtask
  task automatic base();
    out_word = '{16'h8000, 16'h8381, 16'h0000, 16'h03e7, 16'h00c8, 16'h0000,
      16'h0400, 16'h0032, 16'h0022, 16'h0000};
  endtask
  // Frame taken at the middle rising edge
  task automatic send();
    @(negedge clk_sys);
    frame_valid = 1'b1;
    @(negedge clk_sys);
    frame_valid = 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(in_word[0], 16'h0000);
    chk(in_word[9], 16'h0000);
    chk({config_mode, led_flash_green, led_flash_red}, 16'h0000);
    chk(idle_current, 16'h0000);
  endtask
  task automatic t_mirror();
    base();
    send();
    for (int i = 0; i < 10; i++)
      chk(in_word[i], (i == 1) ? 16'h0381 : out_word[i]);
    chk(config_mode, 16'h0001);
    chk({report_fmt_32, param_fmt_32, word_order_big}, 16'h0007);
    chk({input_one_polarity, input_two_polarity}, 16'h0002);
    out_word[0] = 16'ha40a;
    out_word[1] = 16'h0082;
    out_word[7] = 16'h0050;
    send();
    chk(in_word[0], 16'ha40a);
    chk({stall_enable, encoder_enable}, 16'h0003);
    chk({report_fmt_32, param_fmt_32, word_order_big}, 16'h0000);
    chk({input_one_polarity, input_two_polarity}, 16'h0001);
  endtask
  task automatic t_idle();
    chk(idle_current, 16'h0000);
    move_done = 1'b1;
    @(negedge clk_sys);
    move_done = 1'b0;
    chk(idle_current, 16'h0050);
    out_word[7] = 16'h0030;
    send();
    // New idle value arrives with a move end in the same cycle
    out_word[7] = 16'h0028;
    @(negedge clk_sys);
    frame_valid = 1'b1;
    move_done = 1'b1;
    @(negedge clk_sys);
    frame_valid = 1'b0;
    move_done = 1'b0;
    chk(idle_current, 16'h0030);
    move_done = 1'b1;
    @(negedge clk_sys);
    move_done = 1'b0;
    chk(idle_current, 16'h0028);
  endtask
  task automatic t_invalid();
    for (int k = 0; k < 7; k++)
    begin
      base();
      case (k)
        0: out_word[0] = 16'h9000;
        1: out_word[1] = 16'h8385;
        2: out_word[0] = 16'ha000;
        3: out_word[0] = 16'h8009;
        4: out_word[0] = 16'h8007;
        5: out_word[3] = 16'h03e8;
        default:
        begin
          out_word[0] = 16'h8200;
          out_word[1] = 16'h8781;
        end
      endcase
      send();
      chk(config_mode, 16'h0000);
      chk(in_word[0], 16'h2000);
      chk(flash_req, 16'h0000);
    end
  endtask
  task automatic t_readback();
    out_word = '{default: 16'h0000};
    send();
    chk(config_mode, 16'h0000);
    base();
    out_word[1] = 16'h8b81;
    out_word[7] = 16'h0011;
    send();
    chk(config_mode, 16'h0001);
    chk(in_word[0], 16'ha40a);
    chk(in_word[7], 16'h0028);
    out_word[7] = 16'h0012;
    send();
    chk(in_word[7], 16'h0028);
  endtask
  task automatic t_save(input logic ok);
    int n;
    ok_sel = ok;
    base();
    send();
    out_word[1] = 16'h8781;
    send();
    chk(flash_req, 16'h0001);
    chk(flash_data[3], 16'h03e7);
    @(negedge clk_sys);
    chk(flash_req, 16'h0000);
    n = 0;
    while (led_flash_green !== 1'b1 && led_flash_red !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(in_word[9], ok ? 16'haaaa : 16'heeee);
    chk({led_flash_green, led_flash_red}, ok ? 16'h0002 : 16'h0001);
    base();
    out_word[7] = 16'h0040;
    send();
    chk(in_word[7], 16'h0032);
    chk(in_word[9], ok ? 16'haaaa : 16'heeee);
  endtask
  initial
  begin
    fail_count = 0;
    total_checks = 0;
    frame_valid = 1'b0;
    move_done = 1'b0;
    ok_sel = 1'b1;
    out_word = '{default: 16'h0000};
    do_reset();
    t_reset();
    t_mirror();
    t_idle();
    t_invalid();
    t_readback();
    t_save(1'b1);
    do_reset();
    t_reset();
    t_save(1'b0);
    end_sim();
  end
endmodule
